// ===== cmo_pkg.sv
package cmo_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_ADDR    = 8'h04;
	localparam logic [7:0] OFF_CFG     = 8'h08;
	localparam logic [7:0] OFF_TAG_LO  = 8'h0C;
	localparam logic [7:0] OFF_TAG_HI  = 8'h10;
	localparam logic [7:0] OFF_DATA_LO = 8'h14;
	localparam logic [7:0] OFF_DATA_HI = 8'h18;
	localparam logic [7:0] OFF_STAT    = 8'h1C;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// instruction fields
	// ****************************************
	localparam int OP_LSB  = 18;
	localparam int SEL_LSB = 16;

	typedef enum logic [2:0] {
		OP_IDX_INV    = 3'h0,
		OP_LOAD_TAG   = 3'h1,
		OP_STORE_TAG  = 3'h2,
		OP_IMPL       = 3'h3,
		OP_HIT_INV    = 3'h4,
		OP_FILL_HWBI  = 3'h5,
		OP_HIT_WB     = 3'h6,
		OP_FETCH_LOCK = 3'h7
	} cmo_op_t;

	typedef enum logic [1:0] {
		SEL_PRI_I = 2'h0,
		SEL_PRI_D = 2'h1,
		SEL_TER   = 2'h2,
		SEL_SEC   = 2'h3
	} cmo_sel_t;

	// ****************************************
	// line layout: word0 tag_low_staging, word1 tag_high_staging, data
	// ****************************************
	localparam int LINE_OFF_W = 5;
	localparam int IDX_W      = 4;
	localparam int TAG_LSB    = 9;
	localparam int LN_VALID   = 0;
	localparam int LN_DIRTY   = 1;
	localparam int LN_LOCK    = 2;
	localparam int LINE_W     = 128;

	// ****************************************
	// configuration and status
	// ****************************************
	localparam int CFG_ATTR_LSB           = 0;
	localparam int CFG_MP                 = 8;
	localparam int CFG_DWB                = 9;
	localparam logic [31:0] CFG_RESET     = 32'h0000_0200;
	localparam logic [2:0] COH_ATTR_EXCL  = 3'h4;
	localparam logic [2:0] COH_ATTR_SHARE = 3'h5;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_HIT     = 1;
	localparam int STAT_GLOBAL  = 2;
	localparam int STAT_OP_LSB  = 8;
	localparam int STAT_SEL_LSB = 12;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOOK = 5'h02,
		ST_WB   = 5'h04,
		ST_FILL = 5'h08,
		ST_UPD  = 5'h10
	} cmo_state_t;

endpackage

// ===== cmo_line_store.sv
`timescale 1ns/1ps
module cmo_line_store
	import cmo_pkg::*;
#(
	parameter int ENTRIES = 64,
	parameter int IW      = 6
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [IW-1:0]     rd_idx,
	output logic      [LINE_W-1:0] rd_line,
	input  wire logic              wr_en,
	input  wire logic [IW-1:0]     wr_idx,
	input  wire logic [LINE_W-1:0] wr_line
);

	typedef struct packed {
		logic [ENTRIES-1:0][LINE_W-1:0] line;
	} cmo_store_t;

	cmo_store_t s_reg;
	cmo_store_t s_next;

	assign rd_line = s_reg.line[rd_idx];

	// single write port: one line per operation
	always_comb
	begin
		s_next = s_reg;
		if (wr_en)
			s_next.line[wr_idx] = wr_line;
	end

	// reset leaves every line invalid, unlocked
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

endmodule

// ===== cmo_unit.sv
`timescale 1ns/1ps
module cmo_unit
	import cmo_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [63:0]      mem_wdata,
	input  wire logic [63:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             bcast_valid,
	output logic [2:0]       bcast_op,
	output logic [1:0]       bcast_sel,
	output logic [31:0]      bcast_addr
);

	typedef struct packed {
		cmo_state_t        st;
		logic              aw_held;
		logic              w_held;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [31:0]       addr;
		logic [31:0]       cfg;
		logic [31:0]       tag_lo;
		logic [31:0]       tag_hi;
		logic [31:0]       data_lo;
		logic [31:0]       data_hi;
		cmo_op_t           op;
		cmo_sel_t          sel;
		logic              glob;
		logic              hit;
		logic              fill_pend;
		logic [LINE_W-1:0] line;
		logic              mem_req;
		logic              mem_we;
		logic [31:0]       mem_addr;
		logic [63:0]       mem_wdata;
		logic              bcast_valid;
		logic [2:0]        bcast_op;
		logic [1:0]        bcast_sel;
		logic [31:0]       bcast_addr;
	} cmo_regs_t;

	cmo_regs_t          r_reg;
	cmo_regs_t          r_next;
	logic [LINE_W-1:0]  cur;
	logic               store_we;
	logic [IDX_W+1:0]   sidx;
	logic               hit;
	logic               wb_cache;
	logic               dirty_v;
	logic               coherent;
	logic               hit_type;
	logic [7:0]         waddr;
	logic [7:0]         raddr;
	logic               cmd_go;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				m[i*8 +: 8] = d[i*8 +: 8];
		return m;
	endfunction

	// ****************************************
	// line store and lookup
	// ****************************************
	assign sidx     = {r_reg.sel, r_reg.addr[LINE_OFF_W +: IDX_W]};
	assign hit      = cur[LN_VALID] && (cur[31:TAG_LSB] == r_reg.addr[31:TAG_LSB]);
	// only the primary data cache may hold dirty lines
	assign wb_cache = (r_reg.sel == SEL_PRI_D) && r_reg.cfg[CFG_DWB];
	assign dirty_v  = cur[LN_VALID] && cur[LN_DIRTY] && wb_cache;
	assign coherent = r_reg.cfg[CFG_MP] &&
		((r_reg.cfg[CFG_ATTR_LSB +: 3] == COH_ATTR_EXCL) ||
		(r_reg.cfg[CFG_ATTR_LSB +: 3] == COH_ATTR_SHARE));
	assign hit_type = (r_reg.op == OP_HIT_INV) || (r_reg.op == OP_HIT_WB) ||
		((r_reg.op == OP_FILL_HWBI) && (r_reg.sel != SEL_PRI_I));
	assign store_we = (r_reg.st == ST_UPD);

	cmo_line_store #(
		.ENTRIES (4 << IDX_W),
		.IW      (IDX_W + 2)
	) u_store (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rd_idx  (sidx),
		.rd_line (cur),
		.wr_en   (store_we),
		.wr_idx  (sidx),
		.wr_line (r_reg.line)
	);

	// ****************************************
	// bus slave
	// ****************************************
	assign s_axi_awready = !r_reg.aw_held && !r_reg.bvalid;
	assign s_axi_wready  = !r_reg.w_held && !r_reg.bvalid;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_bvalid  = r_reg.bvalid;
	assign s_axi_bresp   = r_reg.bresp;
	assign s_axi_rvalid  = r_reg.rvalid;
	assign s_axi_rdata   = r_reg.rdata;
	assign s_axi_rresp   = r_reg.rresp;
	assign mem_req       = r_reg.mem_req;
	assign mem_we        = r_reg.mem_we;
	assign mem_addr      = r_reg.mem_addr;
	assign mem_wdata     = r_reg.mem_wdata;
	assign bcast_valid   = r_reg.bcast_valid;
	assign bcast_op      = r_reg.bcast_op;
	assign bcast_sel     = r_reg.bcast_sel;
	assign bcast_addr    = r_reg.bcast_addr;
	assign waddr         = {r_reg.awaddr[7:2], 2'b00};
	assign raddr         = {s_axi_araddr[7:2], 2'b00};
	assign cmd_go        = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid &&
		(waddr == OFF_CMD) && (r_reg.st == ST_IDLE);

	always_comb
	begin
		r_next = r_reg;
		r_next.bcast_valid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			r_next.aw_held = 1'b1;
			r_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			r_next.w_held = 1'b1;
			r_next.wdata  = s_axi_wdata;
			r_next.wstrb  = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid)
		begin
			r_next.aw_held = 1'b0;
			r_next.w_held  = 1'b0;
			r_next.bvalid  = 1'b1;
			r_next.bresp   = RESP_OKAY;
			case (waddr)
				OFF_CMD:
				begin
					// a command while busy is dropped; poll busy first
					if (cmd_go)
					begin
						r_next.op  = cmo_op_t'(r_reg.wdata[OP_LSB +: 3]);
						r_next.sel = cmo_sel_t'(r_reg.wdata[SEL_LSB +: 2]);
						r_next.st  = ST_LOOK;
					end
				end
				OFF_ADDR:   r_next.addr   = wmerge(r_reg.addr, r_reg.wdata, r_reg.wstrb);
				OFF_CFG:    r_next.cfg    = wmerge(r_reg.cfg, r_reg.wdata, r_reg.wstrb);
				OFF_TAG_LO: r_next.tag_lo = wmerge(r_reg.tag_lo, r_reg.wdata, r_reg.wstrb);
				OFF_TAG_HI: r_next.tag_hi = wmerge(r_reg.tag_hi, r_reg.wdata, r_reg.wstrb);
				default:    r_next.bresp  = RESP_SLVERR;
			endcase
		end
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && !r_reg.rvalid)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = RESP_OKAY;
			r_next.rdata  = 32'h0000_0000;
			case (raddr)
				OFF_CMD:     r_next.rdata = 32'h0000_0000;
				OFF_ADDR:    r_next.rdata = r_reg.addr;
				OFF_CFG:     r_next.rdata = r_reg.cfg;
				OFF_TAG_LO:  r_next.rdata = r_reg.tag_lo;
				OFF_TAG_HI:  r_next.rdata = r_reg.tag_hi;
				OFF_DATA_LO: r_next.rdata = r_reg.data_lo;
				OFF_DATA_HI: r_next.rdata = r_reg.data_hi;
				OFF_STAT:
				begin
					r_next.rdata[STAT_BUSY]          = (r_reg.st != ST_IDLE);
					r_next.rdata[STAT_HIT]           = r_reg.hit;
					r_next.rdata[STAT_GLOBAL]        = r_reg.glob;
					r_next.rdata[STAT_OP_LSB +: 3]   = r_reg.op;
					r_next.rdata[STAT_SEL_LSB +: 2]  = r_reg.sel;
				end
				default:     r_next.rresp = RESP_SLVERR;
			endcase
		end

		// ****************************************
		// operation sequencer
		// ****************************************
		case (r_reg.st)
			ST_IDLE: ;
			ST_LOOK:
			begin
				r_next.hit       = hit;
				r_next.line      = cur;
				r_next.fill_pend = 1'b0;
				r_next.st        = ST_IDLE;
				// one decision serves every level touched
				r_next.glob      = hit_type && coherent;
				if (hit_type && coherent)
				begin
					r_next.bcast_valid = 1'b1;
					r_next.bcast_op    = r_reg.op;
					r_next.bcast_sel   = r_reg.sel;
					r_next.bcast_addr  = r_reg.addr;
				end
				case (r_reg.op)
					OP_IDX_INV:
					begin
						r_next.line[LN_VALID] = 1'b0;
						r_next.line[LN_LOCK]  = 1'b0;
						r_next.st             = ST_UPD;
					end
					OP_LOAD_TAG:
					begin
						// diagnostic path: no error can come of it
						r_next.tag_lo  = cur[31:0];
						r_next.tag_hi  = cur[63:32];
						r_next.data_lo = cur[95:64];
						r_next.data_hi = cur[127:96];
					end
					OP_STORE_TAG:
					begin
						r_next.line[63:0] = {r_reg.tag_hi, r_reg.tag_lo};
						r_next.st         = ST_UPD;
					end
					OP_IMPL: ;
					OP_HIT_INV:
					begin
						if (hit)
						begin
							r_next.line[LN_VALID] = 1'b0;
							r_next.line[LN_LOCK]  = 1'b0;
							r_next.st             = ST_UPD;
						end
					end
					OP_FILL_HWBI:
					begin
						if (r_reg.sel == SEL_PRI_I)
						begin
							if (!hit)
							begin
								r_next.fill_pend = 1'b1;
								r_next.line[31:0] = {r_reg.addr[31:TAG_LSB],
									{(TAG_LSB-1){1'b0}}, 1'b1};
							end
						end
						else if (hit)
						begin
							r_next.line[LN_VALID] = 1'b0;
							r_next.line[LN_LOCK]  = 1'b0;
							r_next.st             = ST_UPD;
						end
					end
					OP_HIT_WB:
					begin
						if (hit && dirty_v)
							r_next.line[LN_DIRTY] = 1'b0;
					end
					OP_FETCH_LOCK:
					begin
						r_next.st = ST_UPD;
						if (hit)
							r_next.line[LN_LOCK] = 1'b1;
						else
						begin
							r_next.fill_pend = 1'b1;
							r_next.line[31:0] = {r_reg.addr[31:TAG_LSB],
								{(TAG_LSB-3){1'b0}}, 3'b101};
						end
					end
					default: ;
				endcase
				// dirty victim goes out before anything else; a miss on a hit op never
				// reaches here with a request
				if (dirty_v && (r_reg.op != OP_LOAD_TAG) && (r_reg.op != OP_STORE_TAG) &&
					(r_reg.op != OP_IMPL) && (hit || !hit_type) &&
					((r_reg.op != OP_FETCH_LOCK) || !hit))
				begin
					r_next.mem_req   = 1'b1;
					r_next.mem_we    = 1'b1;
					r_next.mem_addr  = {cur[31:TAG_LSB], r_reg.addr[LINE_OFF_W +: IDX_W],
						{LINE_OFF_W{1'b0}}};
					r_next.mem_wdata = cur[127:64];
					r_next.st        = ST_WB;
				end
				else if (r_next.fill_pend)
				begin
					r_next.mem_req  = 1'b1;
					r_next.mem_we   = 1'b0;
					r_next.mem_addr = {r_reg.addr[31:LINE_OFF_W], {LINE_OFF_W{1'b0}}};
					r_next.st       = ST_FILL;
				end
			end
			ST_WB:
			begin
				if (mem_ack)
				begin
					r_next.mem_req = 1'b0;
					r_next.st      = ST_UPD;
					if (r_reg.fill_pend)
					begin
						r_next.mem_req  = 1'b1;
						r_next.mem_we   = 1'b0;
						r_next.mem_addr = {r_reg.addr[31:LINE_OFF_W], {LINE_OFF_W{1'b0}}};
						r_next.st       = ST_FILL;
					end
				end
			end
			ST_FILL:
			begin
				if (mem_ack)
				begin
					r_next.mem_req      = 1'b0;
					r_next.line[127:64] = mem_rdata;
					r_next.st           = ST_UPD;
				end
			end
			ST_UPD:  r_next.st = ST_IDLE;
			default: r_next.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg     <= '0;
			r_reg.st  <= ST_IDLE;
			r_reg.cfg <= CFG_RESET;
		end
		else
			r_reg <= r_next;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_look(cmo_op_t o);
		r_reg.st == ST_LOOK && r_reg.op == o;
	endsequence
	sequence s_wb_ack;
		r_reg.st == ST_WB && mem_ack;
	endsequence

	a_op_decode: assert property (cmd_go |=> r_reg.st == ST_LOOK &&
		r_reg.op == $past(r_reg.wdata[OP_LSB +: 3]) && r_reg.sel == $past(r_reg.wdata[17:16]))
		else $error("op or cache field decoded wrongly");
	a_load_copy: assert property (s_look(OP_LOAD_TAG) |=> r_reg.st == ST_IDLE &&
		r_reg.tag_lo == $past(cur[31:0]) && r_reg.data_hi == $past(cur[127:96]))
		else $error("load tag did not copy line");
	a_store_tag: assert property (s_look(OP_STORE_TAG) |=> store_we &&
		r_reg.line[63:0] == {$past(r_reg.tag_hi), $past(r_reg.tag_lo)})
		else $error("store tag did not write staging");
	a_miss_quiet: assert property (r_reg.st == ST_LOOK && hit_type && !hit
		|=> r_reg.st == ST_IDLE && !mem_req ##1 !store_we)
		else $error("hit-type miss changed state");
	a_wb_first: assert property (s_look(OP_IDX_INV) ##0 dirty_v
		|=> mem_req && mem_we && r_reg.st == ST_WB)
		else $error("dirty line not written back first");
	a_inv_unlock: assert property (store_we && (r_reg.op == OP_IDX_INV ||
		r_reg.op == OP_HIT_INV) |-> !r_reg.line[LN_VALID] && !r_reg.line[LN_LOCK])
		else $error("invalidate left line valid or locked");
	a_bcast_coh: assert property (bcast_valid |-> $past(coherent) && $past(hit_type))
		else $error("broadcast without coherent attribute");
	a_bcast_when: assert property (r_reg.st == ST_LOOK && hit_type && coherent
		|=> bcast_valid && r_reg.glob)
		else $error("coherent hit op not broadcast");
	a_hitwb_clean: assert property (store_we && r_reg.op == OP_HIT_WB
		|-> r_reg.line[LN_VALID] && !r_reg.line[LN_DIRTY])
		else $error("hit writeback left line dirty");
	a_lock_set: assert property (store_we && r_reg.op == OP_FETCH_LOCK
		|-> r_reg.line[LN_VALID] && r_reg.line[LN_LOCK])
		else $error("fetch and lock did not lock");
	a_wb_then_fill: assert property (s_wb_ack and r_reg.fill_pend
		|=> mem_req && !mem_we && r_reg.st == ST_FILL)
		else $error("fill did not follow writeback");

endmodule

// ===== cmo_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// memory partner: acks wait_cyc+1 cycles after it first sees mem_req
// ****************************************
module cmo_mem_model
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [63:0] mem_wdata,
	output logic      [63:0] mem_rdata,
	output logic             mem_ack,
	input  wire logic [3:0]  wait_cyc,
	output int               wb_cnt,
	output int               fill_cnt,
	output logic      [31:0] wb_addr,
	output logic      [63:0] wb_data
);
	logic [3:0] cnt_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg <= 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 64'h0;
			wb_cnt <= 0;
			fill_cnt <= 0;
			wb_addr <= 32'h0;
			wb_data <= 64'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			// outside an ack the data toggles, so stale reads show
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
			begin
				if (cnt_reg >= wait_cyc)
				begin
					mem_ack <= 1'b1;
					cnt_reg <= 4'h0;
					mem_rdata <= {~mem_addr, mem_addr};
					if (mem_we)
					begin
						wb_cnt <= wb_cnt + 1;
						wb_addr <= mem_addr;
						wb_data <= mem_wdata;
					end
					else
						fill_cnt <= fill_cnt + 1;
				end
				else
					cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
endmodule

// ===== cmo_unit_tb_top.sv
`timescale 1ns/1ps
module cmo_unit_tb_top
	import cmo_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, mem_req, mem_we, mem_ack, bcast_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, bcast_addr, wb_addr, bc_addr;
	logic [3:0]  s_axi_wstrb, wait_cyc;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bcast_sel, bc_sel;
	logic [63:0] mem_wdata, mem_rdata, wb_data;
	logic [2:0]  bcast_op, bc_op;
	int          wb_cnt, fill_cnt, bc_n, cyc, err_total, comparisons, w0, f0;
	int          seed = 40;

	cmo_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .bcast_valid, .bcast_op,
		.bcast_sel, .bcast_addr);
	cmo_mem_model mem (.aclk, .aresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .wait_cyc, .wb_cnt, .fill_cnt, .wb_addr, .wb_data);

	// ****************************************
	// clock, watchdog, broadcast monitor
	// ****************************************
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			end_of_test();
		end
		if (aresetn && bcast_valid)
		begin
			bc_n++;
			bc_op = bcast_op;
			bc_sel = bcast_sel;
			bc_addr = bcast_addr;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_of_test();
		$display("err_total %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				done = 1'b1;
				chk(s_axi_bresp, er, "write resp");
			end
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
			begin
				done = 1'b1;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
		s_axi_rready <= 1'b0;
	endtask

	// only implemented combos on line-aligned cacheable addresses
	task automatic op(input logic [2:0] o, input logic [1:0] s, input logic [31:0] a);
		logic [31:0] v;
		logic [1:0]  r;
		axw(OFF_ADDR, a, RESP_OKAY);
		axw(OFF_CMD, {11'h000, o, s, 16'h0000}, RESP_OKAY);
		v = 32'h1;
		while (v[STAT_BUSY])
			axr(OFF_STAT, v, r);
		chk(v[10:8], o, "stat op");
		chk(v[13:12], s, "stat cache");
	endtask

	function automatic logic [31:0] tw(logic [31:0] a, logic l, logic d, logic v);
		return {a[31:9], 6'h00, l, d, v};
	endfunction

	task automatic st(input logic [1:0] s, input logic [31:0] a, input logic [31:0] t);
		axw(OFF_TAG_LO, t, RESP_OKAY);
		op(OP_STORE_TAG, s, a);
	endtask

	task automatic lt(input logic [1:0] s, input logic [31:0] a, output logic [31:0] v);
		logic [1:0] r;
		axw(OFF_TAG_LO, 32'h0, RESP_OKAY);
		op(OP_LOAD_TAG, s, a);
		axr(OFF_TAG_LO, v, r);
		v = v & 32'hFFFF_FE07;
	endtask

	task automatic mem_d(input int dw, input int df, input string m);
		chk(wb_cnt - w0, dw, m);
		chk(fill_cnt - f0, df, m);
		w0 = wb_cnt;
		f0 = fill_cnt;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic [31:0] v, a, b;
		logic [1:0]  r;
		aclk = 1'b0;
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		wait_cyc = 4'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFF_CFG, v, r);
		chk(v, CFG_RESET, "cfg reset");
		axr(8'h20, v, r);
		chk(r, RESP_SLVERR, "unmapped read");
		axw(OFF_STAT, 32'h0, RESP_SLVERR);
		// partial strobes: only the low half of the second write lands
		axw(OFF_TAG_HI, 32'h1111_1111, RESP_OKAY);
		s_axi_wstrb <= 4'h3;
		axw(OFF_TAG_HI, 32'hAAAA_BBBB, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axr(OFF_TAG_HI, v, r);
		chk(v, 32'h1111_BBBB, "byte strobes");
		for (int k = 0; k < 8; k++)
		begin
			a = $random(seed) & 32'hFFFF_FFE0;
			b = tw(a, a[13], 1'b0, 1'b1);
			st(k[1:0], a, b);
			lt(k[1:0], a, v);
			chk(v, b, "tag round trip");
			op(OP_IDX_INV, k[1:0], a);
			lt(k[1:0], a, v);
			chk({v[2], v[0]}, 32'h0, "index inv");
		end
		a = 32'h1234_5660;
		w0 = wb_cnt;
		f0 = fill_cnt;
		st(2'h1, a, tw(a, 1'b1, 1'b1, 1'b1));
		op(OP_IDX_INV, 2'h1, a);
		mem_d(1, 0, "index wb count");
		chk(wb_addr, a, "index wb addr");
		lt(2'h1, a, v);
		chk({v[2], v[0]}, 32'h0, "index wb inv");
		st(2'h1, a, tw(a, 1'b1, 1'b0, 1'b1));
		op(OP_HIT_INV, 2'h1, a ^ 32'h0010_0000);
		mem_d(0, 0, "miss no memory");
		lt(2'h1, a, v);
		chk(v, tw(a, 1'b1, 1'b0, 1'b1), "miss keeps line");
		op(OP_HIT_INV, 2'h1, a);
		lt(2'h1, a, v);
		chk({v[2], v[0]}, 32'h0, "hit inv");
		wait_cyc <= 4'h6;
		st(2'h1, a, tw(a, 1'b0, 1'b1, 1'b1));
		op(OP_HIT_WB, 2'h1, a);
		mem_d(1, 0, "hit wb count");
		lt(2'h1, a, v);
		chk(v, tw(a, 1'b0, 1'b0, 1'b1), "hit wb clean");
		st(2'h1, a, tw(a, 1'b0, 1'b1, 1'b1));
		op(OP_FILL_HWBI, 2'h1, a);
		mem_d(1, 0, "hit wbinv count");
		lt(2'h1, a, v);
		chk(v[0], 1'b0, "hit wbinv");
		wait_cyc <= 4'h0;
		st(2'h0, a, 32'h0);
		op(OP_FILL_HWBI, 2'h0, a);
		mem_d(0, 1, "fill count");
		lt(2'h0, a, v);
		chk(v & 32'hFFFF_FE01, tw(a, 1'b0, 1'b0, 1'b1), "fill tag");
		axr(OFF_DATA_LO, v, r);
		chk(v, a, "load data");
		b = a ^ 32'h0100_0000;
		st(2'h1, a, tw(a, 1'b0, 1'b1, 1'b1));
		st(2'h1, a + 32'h20, tw(a + 32'h20, 1'b0, 1'b0, 1'b1));
		wait_cyc <= 4'h3;
		op(OP_FETCH_LOCK, 2'h1, b);
		mem_d(1, 1, "lock miss mem");
		chk(wb_addr, a, "lock victim addr");
		lt(2'h1, b, v);
		chk(v, tw(b, 1'b1, 1'b0, 1'b1), "lock fill");
		lt(2'h1, a + 32'h20, v);
		chk(v, tw(a + 32'h20, 1'b0, 1'b0, 1'b1), "neighbour");
		st(2'h1, a, tw(a, 1'b0, 1'b0, 1'b1));
		op(OP_FETCH_LOCK, 2'h1, a);
		op(OP_IMPL, 2'h1, a);
		mem_d(0, 0, "lock hit mem");
		lt(2'h1, a, v);
		chk(v, tw(a, 1'b1, 1'b0, 1'b1), "lock hit");
		// line still carries the data filled for b, so the victim data is known
		st(2'h1, a, tw(a, 1'b0, 1'b1, 1'b1));
		op(OP_IDX_INV, 2'h1, a);
		mem_d(1, 0, "victim wb count");
		chk(wb_data[31:0], b, "wb data low");
		chk(wb_data[63:32], ~b, "wb data high");
		axw(OFF_CFG, 32'h0000_0304, RESP_OKAY);
		op(OP_HIT_INV, 2'h1, a);
		chk(bc_n, 1, "bcast count");
		chk({bc_op, bc_sel}, {3'h4, 2'h1}, "bcast op");
		chk(bc_addr, a, "bcast addr");
		axw(OFF_CFG, 32'h0000_0305, RESP_OKAY);
		op(OP_HIT_WB, 2'h3, b);
		chk({bc_n[3:0], bc_op, bc_sel}, {4'h2, 3'h6, 2'h3}, "bcast sec");
		axw(OFF_CFG, 32'h0000_0302, RESP_OKAY);
		op(OP_HIT_INV, 2'h1, a);
		axw(OFF_CFG, 32'h0000_0204, RESP_OKAY);
		op(OP_FILL_HWBI, 2'h1, a);
		chk(bc_n, 2, "no bcast");
		end_of_test();
	end
endmodule
